/* File: pcf_consts.svh */
`ifndef PCF_CONSTS_SVH
`define PCF_CONSTS_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define PCF_NUM_CFG 5'h17
`define PCF_IDX_FRAC_HI 5'h00
`define PCF_IDX_FRAC_MID 5'h02
`define PCF_IDX_FRAC_INT 5'h04
`define PCF_IDX_INT_PRE 5'h06
`define PCF_IDX_PRE_MID 5'h08
`define PCF_IDX_PRE_M1 5'h0A
`define PCF_IDX_M1_MID 5'h0C
`define PCF_IDX_M1_N 5'h0E
`define PCF_IDX_N_BW 5'h10
`define PCF_IDX_BW_TYPE 5'h12
`define PCF_IDX_MODE_OE 5'h14
`define PCF_IDX_ADC_WIN 5'h15
`define PCF_IDX_DOUBLER 5'h16
`define PCF_IDX_STATUS 5'h17
`define PCF_IDX_IRQ_STAT 5'h18
`define PCF_IDX_IRQ_MASK 5'h19
`define PCF_IDX_BLK_PTR 5'h1A
`define PCF_IDX_BLK_DATA 5'h1B

// ****************************************************************
// writable masks, fixed pattern bits and reset values
// ****************************************************************
`define PCF_WMASK_FULL 8'hFF
`define PCF_WMASK_BW_TYPE 8'hFD
`define PCF_WMASK_MODE_OE 8'hC4
`define PCF_WMASK_ADC_WIN 8'h0F
`define PCF_WMASK_DOUBLER 8'h08
`define PCF_FIXED_MODE_OE 8'h10
`define PCF_FIXED_ADC_WIN 8'h60
`define PCF_FIXED_DOUBLER 8'hA1
`define PCF_RST_ADC_WIN 8'h68

// ****************************************************************
// field positions
// ****************************************************************
`define PCF_BIT_OUT_TYPE 0
`define PCF_BIT_OE 2
`define PCF_BIT_DOUBLER 3
`define PCF_BIT_HOLDOVER 6
`define PCF_BIT_CLKBAD 4
`define PCF_BIT_REFBAD 3
`define PCF_BIT_LOCK 2
`define PCF_IRQ_W 4
`define PCF_IRQ_CLKBAD 0
`define PCF_IRQ_REFBAD 1
`define PCF_IRQ_UNLOCK 2
`define PCF_IRQ_HOLDOVER 3

// ****************************************************************
// timing and rate constants
// ****************************************************************
`define PCF_CLK_MHZ 10'h019
`define PCF_LOCK_WIN_BASE_US 10'h002
`define PCF_ADC_DIV_BASE 5'h10

`endif

/* File: pcf_pkg.sv */
package pcf_pkg;

    typedef enum logic [1:0] {
        PCF_MODE_LOW_BW = 2'b00,
        PCF_MODE_SYNTH = 2'b01,
        PCF_MODE_HIGH_BW = 2'b10
    } pcf_mode_e;

    typedef struct packed {
        logic [16:0] ref_predivider;
        logic [16:0] lower_loop_fb_div;
        logic [7:0] upper_fb_int;
        logic [17:0] upper_fb_frac;
        logic [10:0] output_divider;
    } pcf_dividers_s;

    typedef struct packed {
        logic [1:0] upper_loop_filter;
        logic modulator_order;
        logic modulator_enable;
        logic [1:0] upper_charge_pump;
        logic low_current_option;
        logic [3:0] adc_gain;
        logic [1:0] lower_charge_pump;
    } pcf_bw_fields_s;

    typedef struct packed {
        logic holdover_flag;
        logic input_clock_bad;
        logic reference_bad;
        logic pll_locked;
    } pcf_status_s;

    typedef struct packed {
        pcf_mode_e pll_mode_select;
        logic output_standard_sel;
        logic output_enable_bit;
        logic reference_doubler;
        logic [4:0] adc_ref_div;
        logic [9:0] lock_window_cycles;
    } pcf_control_s;

endpackage

/* File: pcf_sync2.sv */
`timescale 1ns/1ps
module pcf_sync2 #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // asynchronous in, synchronised out
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage1;

    // first stage feeds only the second stage
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            stage1 <= '0;
            q <= '0;
        end
        else
        begin
            stage1 <= d;
            q <= stage1;
        end
    end
endmodule

/* File: pcf_bw_decode.sv */
`timescale 1ns/1ps
module pcf_bw_decode
    import pcf_pkg::*;
(
    // packed setting field and active mode
    input wire logic [6:0] internal_setting_field,
    input wire pcf_mode_e mode,
    // per-mode meaning of the field
    output pcf_bw_fields_s fields
);
    always_comb
    begin
        fields = '0;
        fields.low_current_option = internal_setting_field[0];
        if (mode == PCF_MODE_LOW_BW)
        begin
            // upper loop filter and pump fall back to 00 here
            fields.adc_gain = internal_setting_field[6:3];
            fields.lower_charge_pump = internal_setting_field[2:1];
        end
        else
        begin
            fields.upper_loop_filter = internal_setting_field[6:5];
            fields.modulator_order = internal_setting_field[4];
            fields.modulator_enable = internal_setting_field[3];
            fields.upper_charge_pump = internal_setting_field[2:1];
        end
    end
endmodule

/* File: pcf_field_bank.sv */
`timescale 1ns/1ps
`include "pcf_consts.svh"
module pcf_field_bank
    import pcf_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // status pins from the analog loop
    input wire pcf_status_s status_in,
    // configuration towards the loop
    output pcf_dividers_s dividers,
    output pcf_bw_fields_s bw_fields,
    output pcf_control_s control,
    // loop and system side
    output logic osc_freeze,
    output logic lock_pin,
    output logic irq
);

    // ****************************************************************
    // storage and bus decode
    // ****************************************************************
    logic [7:0] cfg [0:22];
    logic [7:0] view [0:23];
    logic [`PCF_IRQ_W-1:0] irq_status;
    logic [`PCF_IRQ_W-1:0] irq_mask;
    logic [`PCF_IRQ_W-1:0] irq_event;
    logic [4:0] blk_ptr;
    pcf_status_s status_sync;
    pcf_status_s status_prev;
    logic [7:0] status_byte;
    logic [7:0] next_rdata;
    logic [4:0] idx;
    logic [4:0] wr_idx;
    logic addr_ok;
    logic setup;
    logic wr_done;
    logic acc_done;
    logic [6:0] bw_raw;
    pcf_mode_e mode;

    assign idx = paddr[6:2];
    assign addr_ok = (paddr[1:0] == 2'h0) && !paddr[7] && (idx <= `PCF_IDX_BLK_DATA);
    assign setup = psel && !penable;
    // zero wait states: every access phase completes at its first edge
    assign pready = 1'b1;
    assign acc_done = psel && penable && addr_ok;
    assign wr_done = acc_done && pwrite;
    assign wr_idx = (idx == `PCF_IDX_BLK_DATA) ? blk_ptr : idx;

    function automatic logic [7:0] wmask(input logic [4:0] i);
        case (i)
            `PCF_IDX_BW_TYPE: wmask = `PCF_WMASK_BW_TYPE;
            `PCF_IDX_MODE_OE: wmask = `PCF_WMASK_MODE_OE;
            `PCF_IDX_ADC_WIN: wmask = `PCF_WMASK_ADC_WIN;
            `PCF_IDX_DOUBLER: wmask = `PCF_WMASK_DOUBLER;
            default: wmask = i[0] ? 8'h00 : `PCF_WMASK_FULL;
        endcase
    endfunction

    function automatic logic [7:0] reset_value(input logic [4:0] i);
        case (i)
            `PCF_IDX_MODE_OE: reset_value = `PCF_FIXED_MODE_OE;
            `PCF_IDX_ADC_WIN: reset_value = `PCF_RST_ADC_WIN;
            `PCF_IDX_DOUBLER: reset_value = `PCF_FIXED_DOUBLER;
            default: reset_value = 8'h00;
        endcase
    endfunction

    // ****************************************************************
    // configuration bytes
    // ****************************************************************
    // masked write keeps reserved and fixed-pattern bits; stray ones written
    // by a careless host never reach the loop
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < 23; i++)
            begin
                cfg[i] <= reset_value(5'(i));
            end
        end
        else if (wr_done && (wr_idx < `PCF_NUM_CFG))
        begin
            cfg[wr_idx] <= (pwdata[7:0] & wmask(wr_idx)) | (cfg[wr_idx] & ~wmask(wr_idx));
        end
    end

    // ****************************************************************
    // block transfer pointer
    // ****************************************************************
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            blk_ptr <= 5'h00;
        end
        else if (acc_done && (idx == `PCF_IDX_BLK_DATA))
        begin
            // ascending walk; wraps after the status byte
            blk_ptr <= (blk_ptr == `PCF_IDX_STATUS) ? 5'h00 : blk_ptr + 5'h01;
        end
        else if (wr_done && (idx == `PCF_IDX_BLK_PTR) && (pwdata[4:0] <= `PCF_IDX_STATUS))
        begin
            blk_ptr <= pwdata[4:0];
        end
    end

    // ****************************************************************
    // status pins
    // ****************************************************************
    pcf_sync2 #(
        .WIDTH(4)
    ) u_status_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .d(status_in),
        .q(status_sync)
    );

    // flags follow the pins, so they clear themselves once a source is good
    always_comb
    begin
        status_byte = 8'h00;
        status_byte[`PCF_BIT_HOLDOVER] = status_sync.holdover_flag;
        status_byte[`PCF_BIT_CLKBAD] = status_sync.input_clock_bad;
        status_byte[`PCF_BIT_REFBAD] = status_sync.reference_bad;
        status_byte[`PCF_BIT_LOCK] = status_sync.pll_locked;
    end

    assign lock_pin = status_sync.pll_locked;
    assign osc_freeze = status_sync.holdover_flag;

    // ****************************************************************
    // interrupts
    // ****************************************************************
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            status_prev <= '0;
        end
        else
        begin
            status_prev <= status_sync;
        end
    end

    always_comb
    begin
        irq_event = '0;
        irq_event[`PCF_IRQ_CLKBAD] = status_sync.input_clock_bad && !status_prev.input_clock_bad;
        irq_event[`PCF_IRQ_REFBAD] = status_sync.reference_bad && !status_prev.reference_bad;
        irq_event[`PCF_IRQ_UNLOCK] = !status_sync.pll_locked && status_prev.pll_locked;
        irq_event[`PCF_IRQ_HOLDOVER] = status_sync.holdover_flag && !status_prev.holdover_flag;
    end

    // write one to clear; a new event in the same cycle wins
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            irq_status <= '0;
        end
        else if (wr_done && (idx == `PCF_IDX_IRQ_STAT))
        begin
            irq_status <= (irq_status & ~pwdata[`PCF_IRQ_W-1:0]) | irq_event;
        end
        else
        begin
            irq_status <= irq_status | irq_event;
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            irq_mask <= '0;
        end
        else if (wr_done && (idx == `PCF_IDX_IRQ_MASK))
        begin
            irq_mask <= pwdata[`PCF_IRQ_W-1:0];
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ****************************************************************
    // read path
    // ****************************************************************
    always_comb
    begin
        for (int i = 0; i < 23; i++)
        begin
            view[i] = cfg[i];
        end
        view[23] = status_byte;
    end

    always_comb
    begin
        next_rdata = 8'h00;
        case (idx)
            `PCF_IDX_IRQ_STAT: next_rdata = {4'h0, irq_status};
            `PCF_IDX_IRQ_MASK: next_rdata = {4'h0, irq_mask};
            `PCF_IDX_BLK_PTR: next_rdata = {3'h0, blk_ptr};
            `PCF_IDX_BLK_DATA: next_rdata = view[blk_ptr];
            default: next_rdata = (idx <= `PCF_IDX_STATUS) ? view[idx] : 8'h00;
        endcase
    end

    // read data is sampled in the setup cycle so it comes from a flop
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            prdata <= addr_ok ? {24'h00_0000, next_rdata} : 32'h0000_0000;
            pslverr <= !addr_ok;
        end
    end

    // ****************************************************************
    // field assembly and decode
    // ****************************************************************
    assign dividers.upper_fb_frac = {cfg[0], cfg[2], cfg[4][7:6]};
    assign dividers.upper_fb_int = {cfg[4][5:0], cfg[6][7:6]};
    assign dividers.ref_predivider = {cfg[6][5:0], cfg[8], cfg[10][7:5]};
    assign dividers.lower_loop_fb_div = {cfg[10][4:0], cfg[12], cfg[14][7:4]};
    assign dividers.output_divider = {cfg[14][3:0], cfg[16][7:1]};
    assign bw_raw = {cfg[16][0], cfg[18][7:2]};

    always_comb
    begin
        case (cfg[20][7:6])
            2'h0: mode = PCF_MODE_LOW_BW;
            2'h1: mode = PCF_MODE_SYNTH;
            default: mode = PCF_MODE_HIGH_BW;
        endcase
    end

    pcf_bw_decode u_bw_decode (
        .internal_setting_field(bw_raw),
        .mode(mode),
        .fields(bw_fields)
    );

    assign control.pll_mode_select = mode;
    assign control.output_standard_sel = cfg[18][`PCF_BIT_OUT_TYPE];
    assign control.output_enable_bit = cfg[20][`PCF_BIT_OE];
    assign control.reference_doubler = cfg[22][`PCF_BIT_DOUBLER];
    // divider against the undoubled reference; unused outside low bandwidth
    assign control.adc_ref_div = (mode == PCF_MODE_LOW_BW) ?
        (`PCF_ADC_DIV_BASE >> cfg[21][3:2]) : 5'h00;
    assign control.lock_window_cycles =
        (`PCF_LOCK_WIN_BASE_US << cfg[21][1:0]) * `PCF_CLK_MHZ;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    out_standard_a: assert property (wr_done && idx == `PCF_IDX_BW_TYPE |=>
        control.output_standard_sel == $past(pwdata[0]))
        else $error("output standard does not follow write");
    pre_divider_a: assert property (wr_done && idx == `PCF_IDX_PRE_MID |=>
        dividers.ref_predivider[10:3] == $past(pwdata[7:0]))
        else $error("pre-divider middle byte wrong");
    frac_high_a: assert property (wr_done && idx == `PCF_IDX_FRAC_HI |=>
        dividers.upper_fb_frac[17:10] == $past(pwdata[7:0]))
        else $error("fraction high byte wrong");
    mode_decode_a: assert property (wr_done && idx == `PCF_IDX_MODE_OE && pwdata[7] |=>
        control.pll_mode_select == PCF_MODE_HIGH_BW)
        else $error("mode 1x not high bandwidth");
    out_enable_a: assert property (wr_done && idx == `PCF_IDX_MODE_OE |=>
        control.output_enable_bit == $past(pwdata[2]))
        else $error("output enable does not follow write");
    reserved_zero_a: assert property (setup && addr_ok && idx < `PCF_IDX_MODE_OE && idx[0] |=>
        prdata == 32'h0000_0000)
        else $error("reserved register reads non-zero");
    adc_rate_a: assert property (control.pll_mode_select == PCF_MODE_LOW_BW |->
        control.adc_ref_div == (5'h10 >> cfg[21][3:2]))
        else $error("adc divider wrong");
    lock_window_a: assert property (cfg[21][1:0] == 2'h3 |->
        control.lock_window_cycles == 10'h190)
        else $error("lock window count wrong");
    doubler_a: assert property (wr_done && idx == `PCF_IDX_DOUBLER |=>
        control.reference_doubler == $past(pwdata[3]))
        else $error("doubler does not follow write");
    clkbad_follow_a: assert property (!status_in.input_clock_bad [*3] |->
        !status_byte[`PCF_BIT_CLKBAD])
        else $error("clock bad flag not self clearing");
    refbad_follow_a: assert property (status_in.reference_bad [*3] |->
        status_byte[`PCF_BIT_REFBAD])
        else $error("reference bad flag not set");
    lock_pin_a: assert property ($rose(status_in.pll_locked) ##1 status_in.pll_locked |->
        ##1 lock_pin)
        else $error("lock pin does not mirror lock");
    holdover_freeze_a: assert property (status_in.holdover_flag [*3] |->
        osc_freeze && status_byte[`PCF_BIT_HOLDOVER])
        else $error("holdover does not freeze oscillator");
    upper_fields_a: assert property (mode != PCF_MODE_LOW_BW |->
        bw_fields.upper_loop_filter == bw_raw[6:5] && bw_fields.adc_gain == 4'h0)
        else $error("upper loop fields wrong");
    low_fields_a: assert property (mode == PCF_MODE_LOW_BW |->
        bw_fields.adc_gain == bw_raw[6:3] && bw_fields.upper_charge_pump == 2'h0)
        else $error("low bandwidth fields wrong");
    block_step_a: assert property (acc_done && idx == `PCF_IDX_BLK_DATA &&
        blk_ptr != `PCF_IDX_STATUS |=> blk_ptr == $past(blk_ptr) + 5'h01)
        else $error("block pointer does not ascend");
    status_ro_a: assert property (wr_done && idx == `PCF_IDX_STATUS |=>
        $stable(cfg[22]) && $stable(cfg[21]))
        else $error("status write disturbed storage");

    blk_read_c: cover property (acc_done && !pwrite && idx == `PCF_IDX_BLK_DATA
        ##[1:9] blk_ptr == 5'h00);
    irq_rise_c: cover property ($rose(irq));
    holdover_c: cover property ($rose(osc_freeze));
    high_bw_c: cover property (mode == PCF_MODE_HIGH_BW && control.output_enable_bit);

endmodule

/* File: pcf_apb_host.sv */
`timescale 1ns/1ps
module pcf_apb_host (
    // clock
    input wire logic clk_sys,
    // apb master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
    end

    // one byte per word; the task itself sends the upper three bytes as zero
    task automatic xfer(input logic wr, input logic [4:0] idx, input logic [7:0] wd,
        output logic [7:0] rd, output logic err);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {1'b0, idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released data lines flip so stale data never looks live
        pwdata <= ~pwdata;
    endtask
endmodule

/* File: pll_config_status_fields_bench.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); fail_count++; end end
module pll_config_status_fields_bench;
    import pcf_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, osc_freeze, lock_pin, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    pcf_status_s status_in = 4'h0;
    pcf_dividers_s dividers;
    pcf_bw_fields_s bw_fields;
    pcf_control_s control;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [7:0] pa [0:8] = '{8'hFF, 8'hFF, 8'hC0, 8'h3F, 8'hFF, 8'hE0, 8'h00, 8'h0F, 8'hFE};
    logic [7:0] pb [0:8] = '{8'h00, 8'h00, 8'h3F, 8'hC0, 8'h00, 8'h1F, 8'hFF, 8'hF0, 8'h01};

    always #20 clk_sys = ~clk_sys;

    pcf_apb_host host_u (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    pcf_field_bank dut_u (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .status_in(status_in), .dividers(dividers), .bw_fields(bw_fields),
        .control(control), .osc_freeze(osc_freeze), .lock_pin(lock_pin), .irq(irq));

    task automatic wr(input logic [4:0] i, input logic [7:0] v);
        logic [7:0] d;
        logic e;
        host_u.xfer(1'b1, i, v, d, e);
        // fields launched at the access edge are looked at once settled
        @(negedge clk_sys);
    endtask

    task automatic rc(input logic [4:0] i, input logic [7:0] x);
        logic [7:0] d;
        logic e;
        host_u.xfer(1'b0, i, 8'h00, d, e);
        `CHK({e, d}, {1'b0, x})
    endtask

    task automatic pins(input logic [3:0] v);
        @(posedge clk_sys) status_in <= v;
        repeat (5) @(posedge clk_sys);
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ****************************************************************
    // hang guard: the whole sequence needs well under a thousand cycles
    // ****************************************************************
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            fail_count++;
            report_and_stop();
        end
    end

    initial
    begin
        logic [7:0] d;
        logic e;
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        rc(5'h14, 8'h10);
        rc(5'h15, 8'h68);
        rc(5'h16, 8'hA1);
        rc(5'h00, 8'h00);
        `CHK(control.lock_window_cycles, 10'h032)
        $display("test reset done");
        for (int k = 0; k < 9; k++) wr(5'(2 * k), pa[k]);
        `CHK(dividers, {17'h1FFFF, 17'h00000, 8'h00, 18'h3FFFF, 11'h7FF})
        for (int k = 0; k < 9; k++) wr(5'(2 * k), pb[k]);
        `CHK(dividers, {17'h00000, 17'h1FFFF, 8'hFF, 18'h00000, 11'h000})
        rc(5'h10, 8'h01);
        rc(5'h01, 8'h00);
        host_u.xfer(1'b0, 5'h1C, 8'h00, d, e);
        `CHK({e, d}, 9'h100)
        $display("test dividers done");
        wr(5'h12, 8'h59);
        for (int m = 0; m < 4; m++)
        begin
            wr(5'h14, {2'(m), 6'h04});
            `CHK(bw_fields, (m == 0) ? 13'h002B : 13'h1580)
            `CHK(control.adc_ref_div, (m == 0) ? 5'h04 : 5'h00)
            `CHK(control.pll_mode_select, (m == 0) ? 2'h0 : (m == 1) ? 2'h1 : 2'h2)
            rc(5'h14, {2'(m), 6'h14});
        end
        `CHK({control.output_standard_sel, control.output_enable_bit}, 2'h3)
        wr(5'h14, 8'h00);
        wr(5'h12, 8'h58);
        `CHK({control.output_standard_sel, control.output_enable_bit}, 2'h0)
        for (int i = 0; i < 4; i++)
        begin
            wr(5'h15, {4'h0, 2'(i), 2'(i)});
            `CHK(control.adc_ref_div, 5'h10 >> i)
            `CHK(control.lock_window_cycles, 10'h032 << i)
            rc(5'h15, {4'h6, 2'(i), 2'(i)});
        end
        wr(5'h16, 8'h08);
        `CHK(control.reference_doubler, 1'b1)
        rc(5'h16, 8'hA9);
        $display("test control done");
        pins(4'h5);
        rc(5'h17, 8'h14);
        `CHK({lock_pin, osc_freeze, irq}, 3'h4)
        wr(5'h19, 8'h01);
        `CHK(irq, 1'b1)
        rc(5'h18, 8'h01);
        wr(5'h18, 8'h01);
        `CHK(irq, 1'b0)
        rc(5'h18, 8'h00);
        pins(4'hA);
        rc(5'h17, 8'h48);
        `CHK({lock_pin, osc_freeze, irq}, 3'h2)
        rc(5'h18, 8'h0E);
        wr(5'h19, 8'h0F);
        `CHK(irq, 1'b1)
        wr(5'h17, 8'hFF);
        rc(5'h17, 8'h48);
        pins(4'h0);
        rc(5'h17, 8'h00);
        $display("test status done");
        wr(5'h1A, 8'h16);
        rc(5'h1B, 8'hA9);
        rc(5'h1B, 8'h00);
        rc(5'h1B, 8'h00);
        rc(5'h1B, 8'h00);
        rc(5'h1B, 8'h00);
        rc(5'h1B, 8'h00);
        rc(5'h1B, 8'h3F);
        $display("test block done");
        report_and_stop();
    end
endmodule
